// >>> core/audio_clkgen_pkg.sv
// Package: register map, reset values and carrier types of the audio clock generators
package audio_clkgen_pkg;

	// Bus geometry
	localparam int ADR_W = 18;
	localparam int DAT_W = 32;

	// Register indices; byte address is four times the index
	localparam logic [15:0] IDX_GEN1_DEN = 16'hf020;
	localparam logic [15:0] IDX_GEN1_NUM = 16'hf021;
	localparam logic [15:0] IDX_GEN2_DEN = 16'hf022;
	localparam logic [15:0] IDX_GEN2_NUM = 16'hf023;
	localparam logic [15:0] IDX_GEN3_DEN = 16'hf024;
	localparam logic [15:0] IDX_GEN3_NUM = 16'hf025;
	localparam logic [15:0] IDX_GEN3_SRC = 16'hf026;
	localparam logic [15:0] IDX_STATUS = 16'hf027;

	// Reset values
	localparam logic [8:0] GEN1_DEN_RST = 9'h006;
	localparam logic [8:0] GEN1_NUM_RST = 9'h001;
	localparam logic [8:0] GEN2_DEN_RST = 9'h009;
	localparam logic [8:0] GEN2_NUM_RST = 9'h001;
	localparam logic [15:0] GEN3_DEN_RST = 16'h0000;
	localparam logic [15:0] GEN3_NUM_RST = 16'h0000;
	localparam logic [15:0] GEN3_SRC_RST = 16'h000e;

	// Source register fields
	localparam int SRC_EXT_BIT = 4;
	localparam logic [3:0] PIN_CODE_LAST = 4'h7;
	localparam logic [3:0] PIN_CODE_SPDIF = 4'he;

	// External reference scaling divisor
	localparam logic [15:0] REF_DIVISOR = 16'h0400;

	// Accumulator width and its saturation bit
	localparam int ACC_W = 24;

	// Per-generator control carried into the fractional engine
	typedef struct packed {
		logic enable;
		logic step;
		logic [15:0] inc;
		logic [15:0] modulus;
	} gen_ctl_t;

	// Per-generator outputs
	typedef struct packed {
		logic tick;
		logic clk_out;
		logic running;
	} gen_out_t;

	// Byte-lane merge of a 16-bit register
	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] data,
		input logic [1:0] sel);
		merge16 = {sel[1] ? data[15:8] : old[15:8], sel[0] ? data[7:0] : old[7:0]};
	endfunction

endpackage

// >>> core/frac_gen.sv
// Fractional rate generator: emits inc/modulus ticks per step
`timescale 1ns/100ps
`default_nettype none
module frac_gen
	import audio_clkgen_pkg::*;
(
	input wire logic clk,
	input wire logic resetn,
	input wire gen_ctl_t ctl,
	output var gen_out_t gout
);

	logic [ACC_W-1:0] acc;

	// Accumulator stops adding near the top so a too-fast ratio saturates, never wraps
	wire reach = acc >= {8'h00, ctl.modulus};
	wire [ACC_W-1:0] add_val = (ctl.step && !acc[ACC_W-1]) ? {8'h00, ctl.inc} : '0;
	wire [ACC_W-1:0] sub_val = reach ? {8'h00, ctl.modulus} : '0;
	wire [ACC_W-1:0] next_acc = acc + add_val - sub_val;

	// Disabled generator is held quiet with a cleared accumulator
	always_ff @(posedge clk) begin
		if (!resetn || !ctl.enable) begin
			acc <= '0;
			gout <= '0;
		end else begin
			acc <= next_acc;
			gout.tick <= reach;
			gout.clk_out <= gout.clk_out ^ reach;
			gout.running <= 1'b1;
		end
	end

endmodule // frac_gen
`default_nettype wire

// >>> core/ref_select.sv
// Reference pin selector with rising-edge detector
`timescale 1ns/100ps
`default_nettype none
module ref_select
	import audio_clkgen_pkg::*;
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic active,
	input wire logic [3:0] code,
	input wire logic [7:0] multipurpose_pin,
	input wire logic spdif_rx_ref,
	output logic ref_level,
	output logic ref_edge,
	output logic code_valid
);

	// Codes 8..13 and 15 pick no source and read as a flat low level
	wire code_is_pin = code <= PIN_CODE_LAST;
	wire code_is_spdif = code == PIN_CODE_SPDIF;
	wire picked = code_is_pin ? multipurpose_pin[code[2:0]] : (code_is_spdif & spdif_rx_ref);

	// Sample, then mark rising edges
	always_ff @(posedge clk) begin
		if (!resetn || !active) begin
			ref_level <= 1'b0;
			ref_edge <= 1'b0;
			code_valid <= 1'b0;
		end else begin
			ref_level <= picked;
			ref_edge <= picked & !ref_level;
			code_valid <= code_is_pin | code_is_spdif;
		end
	end

endmodule // ref_select
`default_nettype wire

// >>> core/audio_clkgen.sv
// Three fractional audio clock generators behind a Wishbone register file
`timescale 1ns/100ps
`default_nettype none

// Operation
// - Generator one numerator, nine bits, resets one
// - Generator one denominator, nine bits, resets six
// - Generator two denominator, nine bits, resets nine
// - Generator two numerator, nine bits, resets one
// - Generator three denominator, sixteen bits, resets zero
// - Generator three numerator, sixteen bits, resets zero
// - Source bit clear: system clock scaled N/M
// - Source bit set: reference times N/1024
// - External reference ignores generator three denominator
// - Four-bit pin field picks external source, resets 0xE
// - Code 1110 selects receiver reference signal
// - Codes 0000-0111 select multipurpose pins 0-7
// - Source register reads 0x000E after reset
module audio_clkgen
	import audio_clkgen_pkg::*;
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [ADR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [DAT_W-1:0] wb_dat_i,
	output logic [DAT_W-1:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic [7:0] multipurpose_pin,
	input wire logic spdif_rx_ref,
	output logic [2:0] gen_tick,
	output logic [2:0] gen_clk
);

	// Settings
	logic [8:0] first_gen_denominator;
	logic [8:0] first_gen_numerator;
	logic [8:0] second_gen_denominator;
	logic [8:0] second_gen_numerator;
	logic [15:0] third_gen_denominator;
	logic [15:0] third_gen_numerator;
	logic external_ref_enable;
	logic [3:0] reference_pin_select;

	// Generator plumbing
	gen_ctl_t gen_ctl [3];
	gen_out_t gen_out [3];
	logic ref_level;
	logic ref_edge;
	logic ref_valid;

	// Bus decode: one request per ack, next one after ack drops
	wire bus_req = wb_cyc_i & wb_stb_i & !wb_ack_o;
	wire wr_en = bus_req & wb_we_i;
	wire [15:0] idx = wb_adr_i[ADR_W-1:2];
	wire [15:0] wdata = wb_dat_i[15:0];
	wire [1:0] wsel = wb_sel_i[1:0];
	wire hit_g1_den = idx == IDX_GEN1_DEN;
	wire hit_g1_num = idx == IDX_GEN1_NUM;
	wire hit_g2_den = idx == IDX_GEN2_DEN;
	wire hit_g2_num = idx == IDX_GEN2_NUM;
	wire hit_g3_den = idx == IDX_GEN3_DEN;
	wire hit_g3_num = idx == IDX_GEN3_NUM;
	wire hit_g3_src = idx == IDX_GEN3_SRC;
	wire hit_status = idx == IDX_STATUS;

	// Register images as read back; reserved bits read zero
	wire [15:0] img_g1_den = {7'h00, first_gen_denominator};
	wire [15:0] img_g1_num = {7'h00, first_gen_numerator};
	wire [15:0] img_g2_den = {7'h00, second_gen_denominator};
	wire [15:0] img_g2_num = {7'h00, second_gen_numerator};
	wire [15:0] img_g3_src = {11'h000, external_ref_enable, reference_pin_select};
	wire [15:0] img_status = {11'h000, ref_valid, ref_level,
		gen_out[2].running, gen_out[1].running, gen_out[0].running};

	// Write values after byte-lane merge
	wire [15:0] m_g1_den = merge16(img_g1_den, wdata, wsel);
	wire [15:0] m_g1_num = merge16(img_g1_num, wdata, wsel);
	wire [15:0] m_g2_den = merge16(img_g2_den, wdata, wsel);
	wire [15:0] m_g2_num = merge16(img_g2_num, wdata, wsel);
	wire [15:0] m_g3_den = merge16(third_gen_denominator, wdata, wsel);
	wire [15:0] m_g3_num = merge16(third_gen_numerator, wdata, wsel);
	wire [15:0] m_g3_src = merge16(img_g3_src, wdata, wsel);

	// Read selection; unmapped words read zero and are still acked
	wire [15:0] rd_word =
		hit_g1_den ? img_g1_den :
		hit_g1_num ? img_g1_num :
		hit_g2_den ? img_g2_den :
		hit_g2_num ? img_g2_num :
		hit_g3_den ? third_gen_denominator :
		hit_g3_num ? third_gen_numerator :
		hit_g3_src ? img_g3_src :
		hit_status ? img_status : 16'h0000;

	// Bus answer: ack one cycle after the request, read data with it
	always_ff @(posedge clk) begin
		if (!resetn) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= '0;
		end else begin
			wb_ack_o <= bus_req;
			wb_dat_o <= (bus_req && !wb_we_i) ? {16'h0000, rd_word} : '0;
		end
	end

	// Generator one settings
	always_ff @(posedge clk) begin
		if (!resetn) begin
			first_gen_numerator <= GEN1_NUM_RST;
			first_gen_denominator <= GEN1_DEN_RST;
		end else begin
			if (wr_en && hit_g1_num)
				first_gen_numerator <= m_g1_num[8:0];
			if (wr_en && hit_g1_den)
				first_gen_denominator <= m_g1_den[8:0];
		end
	end

	// Generator two settings
	always_ff @(posedge clk) begin
		if (!resetn) begin
			second_gen_denominator <= GEN2_DEN_RST;
			second_gen_numerator <= GEN2_NUM_RST;
		end else begin
			if (wr_en && hit_g2_den)
				second_gen_denominator <= m_g2_den[8:0];
			if (wr_en && hit_g2_num)
				second_gen_numerator <= m_g2_num[8:0];
		end
	end

	// Generator three ratio
	always_ff @(posedge clk) begin
		if (!resetn) begin
			third_gen_denominator <= GEN3_DEN_RST;
			third_gen_numerator <= GEN3_NUM_RST;
		end else begin
			if (wr_en && hit_g3_den)
				third_gen_denominator <= m_g3_den;
			if (wr_en && hit_g3_num)
				third_gen_numerator <= m_g3_num;
		end
	end

	// Generator three reference source
	always_ff @(posedge clk) begin
		if (!resetn) begin
			external_ref_enable <= GEN3_SRC_RST[SRC_EXT_BIT];
			reference_pin_select <= GEN3_SRC_RST[3:0];
		end else if (wr_en && hit_g3_src) begin
			external_ref_enable <= m_g3_src[SRC_EXT_BIT];
			reference_pin_select <= m_g3_src[3:0];
		end
	end

	// Generators one and two run off the system clock at N/M
	assign gen_ctl[0] = '{enable: (first_gen_numerator != '0) && (first_gen_denominator != '0),
		step: 1'b1, inc: img_g1_num, modulus: img_g1_den};
	assign gen_ctl[1] = '{enable: (second_gen_numerator != '0) && (second_gen_denominator != '0),
		step: 1'b1, inc: img_g2_num, modulus: img_g2_den};

	// Generator three: M is bypassed for the fixed divisor when external
	wire g3_den_ok = external_ref_enable ? ref_valid : (third_gen_denominator != '0);
	wire [15:0] g3_modulus = external_ref_enable ? REF_DIVISOR : third_gen_denominator;
	wire g3_step = external_ref_enable ? ref_edge : 1'b1;
	assign gen_ctl[2] = '{enable: (third_gen_numerator != '0) && g3_den_ok,
		step: g3_step, inc: third_gen_numerator, modulus: g3_modulus};

	// External reference picker; idle while the system clock is the reference
	ref_select u_ref_select (
		.clk(clk),
		.resetn(resetn),
		.active(external_ref_enable),
		.code(reference_pin_select),
		.multipurpose_pin(multipurpose_pin),
		.spdif_rx_ref(spdif_rx_ref),
		.ref_level(ref_level),
		.ref_edge(ref_edge),
		.code_valid(ref_valid)
	);

	// Three rate engines; ticks beyond one per cycle saturate
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_gen
			frac_gen u_frac_gen (
				.clk(clk),
				.resetn(resetn),
				.ctl(gen_ctl[gi]),
				.gout(gen_out[gi])
			);
			assign gen_tick[gi] = gen_out[gi].tick;
			assign gen_clk[gi] = gen_out[gi].clk_out;
		end
	endgenerate

	// Helper: currently addressed pin level
	wire pin_pick = multipurpose_pin[reference_pin_select[2:0]];

	// Checks on reset values, writes and source routing
	AST_GEN1_NUM_RESET: assert property (@(posedge clk)
		!resetn |=> first_gen_numerator == GEN1_NUM_RST)
		else $error("gen1 numerator reset wrong");

	AST_GEN1_DEN_WRITE: assert property (@(posedge clk) disable iff (!resetn)
		(wr_en && hit_g1_den && wsel == 2'b11)
		|=> first_gen_denominator == $past(wb_dat_i[8:0]))
		else $error("gen1 denominator write lost");

	AST_GEN2_DEN_RESET: assert property (@(posedge clk)
		!resetn |=> second_gen_denominator == GEN2_DEN_RST && wb_ack_o == 1'b0)
		else $error("gen2 denominator reset wrong");

	AST_GEN2_NUM_WRITE: assert property (@(posedge clk) disable iff (!resetn)
		(wr_en && hit_g2_num && wsel[0])
		|=> wb_ack_o && second_gen_numerator[7:0] == $past(wb_dat_i[7:0]))
		else $error("gen2 numerator write lost");

	AST_GEN3_DEN_READ: assert property (@(posedge clk) disable iff (!resetn)
		(bus_req && !wb_we_i && hit_g3_den)
		|=> wb_ack_o && wb_dat_o == {16'h0000, $past(third_gen_denominator)})
		else $error("gen3 denominator readback wrong");

	AST_GEN3_NUM_RESET: assert property (@(posedge clk)
		!resetn |=> third_gen_numerator == GEN3_NUM_RST)
		else $error("gen3 numerator reset wrong");

	AST_PLL_SCALING: assert property (@(posedge clk) disable iff (!resetn)
		!external_ref_enable |-> gen_ctl[2].step && gen_ctl[2].modulus == third_gen_denominator)
		else $error("gen3 system-clock scaling wrong");

	AST_EXT_SCALING: assert property (@(posedge clk) disable iff (!resetn)
		external_ref_enable |-> gen_ctl[2].modulus == REF_DIVISOR
			&& gen_ctl[2].inc == third_gen_numerator && gen_ctl[2].step == ref_edge)
		else $error("gen3 external scaling wrong");

	AST_PIN_ROUTE: assert property (@(posedge clk) disable iff (!resetn)
		(external_ref_enable && reference_pin_select <= PIN_CODE_LAST)
		|=> ref_level == $past(pin_pick) && ref_valid)
		else $error("multipurpose pin not routed");

	AST_SPDIF_ROUTE: assert property (@(posedge clk) disable iff (!resetn)
		(external_ref_enable && reference_pin_select == PIN_CODE_SPDIF)
		|=> ref_level == $past(spdif_rx_ref))
		else $error("receiver reference not routed");

	AST_SRC_RESET: assert property (@(posedge clk)
		!resetn |=> img_g3_src == GEN3_SRC_RST)
		else $error("source register reset wrong");

	AST_ZERO_QUIET: assert property (@(posedge clk) disable iff (!resetn)
		(third_gen_numerator == '0) [*2] |-> !gen_tick[2] && !gen_out[2].running)
		else $error("gen3 ticks with zero numerator");

	AST_ACK_SINGLE: assert property (@(posedge clk) disable iff (!resetn)
		wb_ack_o |=> !wb_ack_o)
		else $error("ack held over two cycles");

	AST_ACK_NEXT_CYCLE: assert property (@(posedge clk) disable iff (!resetn)
		bus_req |=> wb_ack_o)
		else $error("ack not one cycle after request");

	// Read data stands only with ack, so a late sample cannot see a stale word
	AST_DATA_ONLY_WITH_ACK: assert property (@(posedge clk) disable iff (!resetn)
		!wb_ack_o |-> wb_dat_o == '0)
		else $error("read data outside ack");

	// Unmapped words are acked and read zero
	wire hit_any = hit_g1_den | hit_g1_num | hit_g2_den | hit_g2_num | hit_g3_den | hit_g3_num
		| hit_g3_src | hit_status;

	AST_UNMAPPED_READ: assert property (@(posedge clk) disable iff (!resetn)
		(bus_req && !wb_we_i && !hit_any) |=> wb_ack_o && wb_dat_o == '0)
		else $error("unmapped word not read as zero");

	AST_STATUS_RESERVED: assert property (@(posedge clk) disable iff (!resetn)
		(bus_req && !wb_we_i && hit_status) |=> wb_dat_o[31:5] == '0)
		else $error("status reserved bits set");

	// Remaining reset values
	AST_GEN1_DEN_RESET: assert property (@(posedge clk)
		!resetn |=> first_gen_denominator == GEN1_DEN_RST)
		else $error("gen1 denominator reset wrong");

	AST_GEN2_NUM_RESET: assert property (@(posedge clk)
		!resetn |=> second_gen_numerator == GEN2_NUM_RST)
		else $error("gen2 numerator reset wrong");

	AST_GEN3_DEN_RESET: assert property (@(posedge clk)
		!resetn |=> third_gen_denominator == GEN3_DEN_RST)
		else $error("gen3 denominator reset wrong");

	// Remaining writes; a single-lane write must leave the other lane alone
	AST_GEN1_NUM_WRITE: assert property (@(posedge clk) disable iff (!resetn)
		(wr_en && hit_g1_num && wsel == 2'b11)
		|=> first_gen_numerator == $past(wb_dat_i[8:0]))
		else $error("gen1 numerator write lost");

	AST_GEN2_DEN_WRITE: assert property (@(posedge clk) disable iff (!resetn)
		(wr_en && hit_g2_den && wsel == 2'b11)
		|=> second_gen_denominator == $past(wb_dat_i[8:0]))
		else $error("gen2 denominator write lost");

	AST_GEN3_NUM_UPPER_LANE: assert property (@(posedge clk) disable iff (!resetn)
		(wr_en && hit_g3_num && wsel == 2'b10)
		|=> third_gen_numerator == {$past(wb_dat_i[15:8]), $past(third_gen_numerator[7:0])})
		else $error("gen3 numerator lane merge wrong");

	AST_SRC_WRITE: assert property (@(posedge clk) disable iff (!resetn)
		(wr_en && hit_g3_src && wsel == 2'b11)
		|=> external_ref_enable == $past(wb_dat_i[SRC_EXT_BIT])
			&& reference_pin_select == $past(wb_dat_i[3:0]))
		else $error("source register write lost");

	// Reference path rests while the system clock is the reference
	AST_REF_IDLE: assert property (@(posedge clk) disable iff (!resetn)
		!external_ref_enable |=> !ref_level && !ref_valid)
		else $error("reference path active in system mode");

	// Quiet generator three: zero denominator in system mode
	AST_ZERO_DEN_QUIET: assert property (@(posedge clk) disable iff (!resetn)
		(!external_ref_enable && third_gen_denominator == '0) [*2]
		|-> !gen_tick[2] && !gen_out[2].running)
		else $error("gen3 ticks with zero denominator");

	// Valid flag lags the code by one cycle, hence three cycles of bad code
	AST_BAD_CODE_QUIET: assert property (@(posedge clk) disable iff (!resetn)
		(external_ref_enable && reference_pin_select > PIN_CODE_LAST
			&& reference_pin_select != PIN_CODE_SPDIF) [*3]
		|-> !gen_tick[2] && !gen_out[2].running)
		else $error("gen3 runs from an unused pin code");

	// Each tick flips the generated clock
	AST_TICK_FLIPS_CLK0: assert property (@(posedge clk) disable iff (!resetn)
		gen_tick[0] |-> gen_clk[0] != $past(gen_clk[0]))
		else $error("gen1 clock did not flip on tick");

	AST_TICK_FLIPS_CLK1: assert property (@(posedge clk) disable iff (!resetn)
		gen_tick[1] |-> gen_clk[1] != $past(gen_clk[1]))
		else $error("gen2 clock did not flip on tick");

endmodule // audio_clkgen
`default_nettype wire

// >>> tb/ref_source_model.sv
// Model of the external reference source driving one chosen input
`timescale 1ns/100ps
`default_nettype none
module ref_source_model (
	input wire logic clk,
	input wire logic run,
	input wire logic [3:0] code,
	input wire logic [7:0] half_period,
	output logic [7:0] multipurpose_pin,
	output logic spdif_rx_ref
);
	logic [7:0] cnt;
	logic wave;

	// Even split of high and low keeps the duty cycle at half
	always_ff @(posedge clk) begin
		if (!run) begin
			cnt <= 8'h00;
			wave <= 1'b0;
		end else if (cnt == half_period - 8'h01) begin
			cnt <= 8'h00;
			wave <= ~wave;
		end else begin
			cnt <= cnt + 8'h01;
		end
	end

	// Only the chosen line carries the wave; pulled-down lines rest low
	assign multipurpose_pin = (code <= 4'h7) ? ((8'h01 << code) & {8{wave}}) : 8'h00;
	assign spdif_rx_ref = (code == 4'he) & wave;
endmodule // ref_source_model
`default_nettype wire

// >>> tb/audio_clock_generator_ratios_test.sv
// Self-checking bench for the audio clock generators
`timescale 1ns/100ps
`default_nettype none
module audio_clock_generator_ratios_test;
	import audio_clkgen_pkg::*;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic wb_cyc_i = 1'b0;
	logic wb_stb_i = 1'b0;
	logic wb_we_i = 1'b0;
	logic [ADR_W-1:0] wb_adr_i = '0;
	logic [3:0] wb_sel_i = 4'h0;
	logic [DAT_W-1:0] wb_dat_i = '0;
	logic [DAT_W-1:0] wb_dat_o;
	logic wb_ack_o;
	logic [7:0] multipurpose_pin;
	logic spdif_rx_ref;
	logic [2:0] gen_tick;
	logic [2:0] gen_clk;
	logic ref_run = 1'b0;
	logic [3:0] ref_code = 4'h0;
	int n_errors = 0;
	int n_checks = 0;

	// 250 MHz clock
	always #2 clk = ~clk;

	audio_clkgen u_dut (.clk(clk), .resetn(resetn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .multipurpose_pin(multipurpose_pin),
		.spdif_rx_ref(spdif_rx_ref), .gen_tick(gen_tick), .gen_clk(gen_clk));

	ref_source_model u_ref (.clk(clk), .run(ref_run), .code(ref_code), .half_period(8'h04),
		.multipurpose_pin(multipurpose_pin), .spdif_rx_ref(spdif_rx_ref));

	task automatic end_of_test();
		$display("checks %0d, mismatches %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask

	// Reset is held six cycles; every scenario starts from it
	task automatic do_reset();
		resetn <= 1'b0;
		repeat (6) @(posedge clk);
		resetn <= 1'b1;
		@(posedge clk);
	endtask

	// Classic cycle: hold until ack, then release for at least one cycle
	task automatic wb_cycle(input logic [15:0] idx, input logic we, input logic [15:0] data,
		input logic [3:0] sel, output logic [31:0] rdata);
		int i;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= {idx, 2'b00};
		wb_sel_i <= sel;
		wb_dat_i <= {16'h0000, data};
		for (i = 0; i < 16; i++) begin
			@(posedge clk);
			if (wb_ack_o === 1'b1) break;
		end
		if (i == 16) begin
			n_errors++;
			$display("unexpected bus ack: expected 1, seen none");
			end_of_test();
		end
		rdata = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge clk);
	endtask

	task automatic wr(input logic [15:0] idx, input logic [15:0] data);
		logic [31:0] d;
		wb_cycle(idx, 1'b1, data, 4'h3, d);
	endtask

	task automatic rd(input string what, input logic [15:0] idx, input logic [31:0] exp);
		logic [31:0] d;
		wb_cycle(idx, 1'b0, 16'h0000, 4'h3, d);
		check(what, exp, d);
	endtask

	// Settle, then count ticks of one generator over a whole number of periods
	// The generated clock must change exactly once per tick
	task automatic rate(input string what, input int g, input int cycles, input int exp);
		int n;
		int n_flip;
		logic prev;
		n = 0;
		n_flip = 0;
		repeat (40) @(posedge clk);
		prev = gen_clk[g];
		repeat (cycles) begin
			@(posedge clk);
			if (gen_tick[g] === 1'b1) n++;
			if (gen_clk[g] !== prev) n_flip++;
			prev = gen_clk[g];
		end
		check(what, exp, n);
		check({what, " clock flips"}, exp, n_flip);
	endtask

	task automatic test_reset_values();
		do_reset();
		rd("gen1 denominator", IDX_GEN1_DEN, 32'h0000_0006);
		rd("gen1 numerator", IDX_GEN1_NUM, 32'h0000_0001);
		rd("gen2 denominator", IDX_GEN2_DEN, 32'h0000_0009);
		rd("gen2 numerator", IDX_GEN2_NUM, 32'h0000_0001);
		rd("gen3 denominator", IDX_GEN3_DEN, 32'h0000_0000);
		rd("gen3 numerator", IDX_GEN3_NUM, 32'h0000_0000);
		rd("gen3 source", IDX_GEN3_SRC, 32'h0000_000e);
		rd("status", IDX_STATUS, 32'h0000_0003);
		$display("reset values done");
	endtask

	task automatic test_register_access();
		logic [31:0] d;
		do_reset();
		wr(IDX_GEN1_DEN, 16'hffff);
		wr(IDX_GEN1_NUM, 16'hffff);
		wr(IDX_GEN2_DEN, 16'hffff);
		wr(IDX_GEN2_NUM, 16'hffff);
		wr(IDX_GEN3_DEN, 16'hffff);
		wr(IDX_GEN3_SRC, 16'hffff);
		wr(16'hf030, 16'hffff);
		wb_cycle(IDX_GEN3_NUM, 1'b1, 16'h12ab, 4'h2, d);
		rd("gen1 denominator", IDX_GEN1_DEN, 32'h0000_01ff);
		rd("gen1 numerator", IDX_GEN1_NUM, 32'h0000_01ff);
		rd("gen2 denominator", IDX_GEN2_DEN, 32'h0000_01ff);
		rd("gen2 numerator", IDX_GEN2_NUM, 32'h0000_01ff);
		rd("gen3 denominator", IDX_GEN3_DEN, 32'h0000_ffff);
		rd("gen3 numerator upper lane", IDX_GEN3_NUM, 32'h0000_1200);
		rd("gen3 source", IDX_GEN3_SRC, 32'h0000_001f);
		rd("unmapped", 16'hf030, 32'h0000_0000);
		$display("register access done");
	endtask

	task automatic test_pll_rates();
		do_reset();
		ref_code <= 4'he;
		ref_run <= 1'b1;
		rate("gen1 ticks", 0, 180, 30);
		rate("gen2 ticks", 1, 180, 20);
		rate("gen3 idle ticks", 2, 180, 0);
		wr(IDX_GEN1_NUM, 16'h0002);
		wr(IDX_GEN1_DEN, 16'h0009);
		rate("gen1 2/9 ticks", 0, 180, 40);
		wr(IDX_GEN3_NUM, 16'h0003);
		rate("gen3 zero denominator", 2, 160, 0);
		wr(IDX_GEN3_DEN, 16'h0008);
		rate("gen3 3/8 ticks", 2, 160, 60);
		ref_run <= 1'b0;
		$display("system reference rates done");
	endtask

	// Each valid code locks onto its own line and ignores the source moved to the next code
	task automatic test_external_reference();
		for (int c = 0; c < 15; c++) begin
			if (c > 7 && c != 14) continue;
			do_reset();
			ref_code <= 4'(c);
			ref_run <= 1'b1;
			wr(IDX_GEN3_NUM, 16'h0400);
			wr(IDX_GEN3_SRC, 16'h0010 | 16'(c));
			rate("external ticks", 2, 80, 10);
			wr(IDX_GEN3_NUM, 16'h0200);
			rate("external half ticks", 2, 160, 10);
			ref_code <= 4'(c + 1);
			rate("unselected line ticks", 2, 80, 0);
			ref_run <= 1'b0;
		end
		$display("external reference done");
	endtask

	initial begin
		test_reset_values();
		test_register_access();
		test_pll_rates();
		test_external_reference();
		end_of_test();
	end
endmodule // audio_clock_generator_ratios_test
`default_nettype wire
